// >>> common/ddp_params.svh
// Constants for the dual data pointer control block
`ifndef DDP_PARAMS_SVH
`define DDP_PARAMS_SVH

`define DDP_ADDR_CONTROL  8'ha7
`define DDP_ADDR_LOW      8'h82
`define DDP_ADDR_HIGH     8'h83
`define DDP_ADDR_PAGE     8'h84
`define DDP_CONTROL_RESET 8'h00
`define DDP_PTR_RESET     24'h000000
`define DDP_BIT_SELECT    0
`define DDP_BIT_MAIN_LO   2
`define DDP_BIT_MAIN_HI   3
`define DDP_BIT_SHAD_LO   4
`define DDP_BIT_SHAD_HI   5
`define DDP_BIT_TOGGLE    6
`define DDP_CONTROL_MASK  8'h7d

`endif

// >>> common/ddp_pkg.sv
// Types for the dual data pointer control block
package ddp_pkg;
  // Per-pointer automatic adjust modes
  typedef enum logic [1:0] {
    DDP_MODE_NONE = 2'h0,
    DDP_MODE_INC  = 2'h1,
    DDP_MODE_DEC  = 2'h2,
    DDP_MODE_LSB  = 2'h3
  } ddp_mode_e;
  typedef logic [23:0] ddp_ptr_t;
endpackage : ddp_pkg

// >>> hdl/ddp_adjust.sv
// Post-move pointer adjust unit
`timescale 1ns/100ps
module ddp_adjust
  import ddp_pkg::*;
(
  input  wire ddp_pkg::ddp_ptr_t  ptr_in,   // Pointer before move
  input  wire ddp_pkg::ddp_mode_e mode_in,  // Adjust mode
  output ddp_pkg::ddp_ptr_t       ptr_out   // Pointer after move
);
  // Mode decode
  always_comb
  begin
    unique case (mode_in)
      DDP_MODE_NONE: ptr_out = ptr_in;
      DDP_MODE_INC:  ptr_out = ptr_in + 24'h000001;
      DDP_MODE_DEC:  ptr_out = ptr_in - 24'h000001;
      DDP_MODE_LSB:  ptr_out = {ptr_in[23:1], ~ptr_in[0]};
    endcase
  end
endmodule : ddp_adjust

// >>> hdl/ddp_core.sv
// Dual data pointer with control register on the core register port
`timescale 1ns/100ps
`include "ddp_params.svh"
module ddp_core
  import ddp_pkg::*;
(
  input  wire logic              ref_clk_in,      // Core clock
  input  wire logic              reset_n_in,      // Sync reset, active low
  input  wire logic [7:0]        reg_addr_in,     // Register address
  input  wire logic              reg_wr_in,       // Write strobe
  input  wire logic [7:0]        reg_wdata_in,    // Write data
  input  wire logic              ptr_load_in,     // Full pointer load strobe
  input  wire ddp_pkg::ddp_ptr_t ptr_load_data_in, // Full pointer load value
  input  wire logic              ptr_move_in,     // Pointer-addressed move done
  output logic [7:0]             reg_rdata_out,   // Registered read data
  output ddp_pkg::ddp_ptr_t      active_pointer_out, // Active pointer
  output logic [7:0]             data_pointer_control_out // Control value
);
  import ddp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [7:0] data_pointer_control;  // Control register
  ddp_ptr_t   main_ptr;              // Main pointer
  ddp_ptr_t   shadow_ptr;            // Shadow pointer
  ddp_ptr_t   next_main;             // Main after adjust
  ddp_ptr_t   next_shadow;           // Shadow after adjust
  ddp_ptr_t   active_now;            // Currently selected pointer
  logic       pointer_select;        // Select bit
  logic       auto_toggle_enable;    // Auto swap enable
  ddp_mode_e  main_mode;             // Main adjust mode
  ddp_mode_e  shadow_mode;           // Shadow adjust mode
  logic       wr_ctrl;               // Control write hit
  logic       wr_low;                // Low byte write hit
  logic       wr_high;               // High byte write hit
  logic       wr_page;               // Page byte write hit

  // Field extraction
  // Fields are decoded straight from the stored control byte,
  // so a control write acts on the very next move.
  // Bit 1 and bit 7 never hold a one, which keeps an
  // increment of the whole byte from carrying into the modes.
  assign pointer_select     = data_pointer_control[`DDP_BIT_SELECT];
  assign auto_toggle_enable = data_pointer_control[`DDP_BIT_TOGGLE];
  assign main_mode   = ddp_mode_e'({data_pointer_control[`DDP_BIT_MAIN_HI],
                                    data_pointer_control[`DDP_BIT_MAIN_LO]});
  assign shadow_mode = ddp_mode_e'({data_pointer_control[`DDP_BIT_SHAD_HI],
                                    data_pointer_control[`DDP_BIT_SHAD_LO]});
  // Active pointer mux
  assign active_now = pointer_select ? shadow_ptr : main_ptr;

  // Address decode
  // One compare per mapped address; unmapped writes fall through
  // and leave every register untouched.
  assign wr_ctrl = reg_wr_in && (reg_addr_in == `DDP_ADDR_CONTROL);
  assign wr_low  = reg_wr_in && (reg_addr_in == `DDP_ADDR_LOW);
  assign wr_high = reg_wr_in && (reg_addr_in == `DDP_ADDR_HIGH);
  assign wr_page = reg_wr_in && (reg_addr_in == `DDP_ADDR_PAGE);

  ////////////////////////////////////////////////////////////////////////////
  // Adjust units
  ddp_adjust u_adj_main (
    .ptr_in  (main_ptr),
    .mode_in (main_mode),
    .ptr_out (next_main)
  );
  ddp_adjust u_adj_shadow (
    .ptr_in  (shadow_ptr),
    .mode_in (shadow_mode),
    .ptr_out (next_shadow)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Byte replace helper
  function automatic ddp_ptr_t put_byte(input ddp_ptr_t p, input logic [1:0] idx,
                                        input logic [7:0] b);
    ddp_ptr_t r;
    r = p;
    unique case (idx)
      2'h0: r[7:0]   = b;
      2'h1: r[15:8]  = b;
      default: r[23:16] = b;
    endcase
    return r;
  endfunction : put_byte

  // Apply a register write or load to a given pointer
  // A full load beats a byte write in the same cycle;
  // only the selected pointer ever calls this.
  function automatic ddp_ptr_t write_ptr(input ddp_ptr_t p);
    ddp_ptr_t r;
    r = p;
    if (ptr_load_in)
      r = ptr_load_data_in;
    else if (wr_low)
      r = put_byte(p, 2'h0, reg_wdata_in);
    else if (wr_high)
      r = put_byte(p, 2'h1, reg_wdata_in);
    else if (wr_page)
      r = put_byte(p, 2'h2, reg_wdata_in);
    return r;
  endfunction : write_ptr

  ////////////////////////////////////////////////////////////////////////////
  // Control register
  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
      data_pointer_control <= `DDP_CONTROL_RESET;
    else if (wr_ctrl)
      // Bits 7 and 1 stay zero, so increment just flips select
      data_pointer_control <= reg_wdata_in & `DDP_CONTROL_MASK;
    else if (ptr_move_in && auto_toggle_enable)
      // Swap after the adjust of the same move
      data_pointer_control[`DDP_BIT_SELECT] <= ~pointer_select;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main pointer
  // A move beats a byte write or load, so the adjust is never lost.
  // The idle pointer holds its value whatever the core does.
  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
      main_ptr <= `DDP_PTR_RESET;
    else if (!pointer_select)
    begin
      if (ptr_move_in)
        main_ptr <= next_main;
      else
        main_ptr <= write_ptr(main_ptr);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shadow pointer
  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
      shadow_ptr <= `DDP_PTR_RESET;
    else if (pointer_select)
    begin
      if (ptr_move_in)
        shadow_ptr <= next_shadow;
      else
        shadow_ptr <= write_ptr(shadow_ptr);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered read data, unmapped reads zero
  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
      reg_rdata_out <= 8'h00;
    else
    begin
      unique case (reg_addr_in)
        `DDP_ADDR_CONTROL: reg_rdata_out <= data_pointer_control;
        `DDP_ADDR_LOW:     reg_rdata_out <= active_now[7:0];
        `DDP_ADDR_HIGH:    reg_rdata_out <= active_now[15:8];
        `DDP_ADDR_PAGE:    reg_rdata_out <= active_now[23:16];
        default:           reg_rdata_out <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered views for the core
  // Both views lag the state by one cycle; the core must allow for it.
  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      active_pointer_out       <= `DDP_PTR_RESET;
      data_pointer_control_out <= `DDP_CONTROL_RESET;
    end
    else
    begin
      active_pointer_out       <= active_now;
      data_pointer_control_out <= data_pointer_control;
    end
  end
endmodule : ddp_core

// >>> verif/ddp_core_sva.sv
// Port assertions for the dual data pointer block
`timescale 1ns/100ps
module ddp_core_sva (
  input wire logic ref_clk_in, reset_n_in, reg_wr_in, ptr_load_in, ptr_move_in,
  input wire logic [7:0] reg_addr_in, reg_rdata_out, data_pointer_control_out,
  input wire ddp_pkg::ddp_ptr_t active_pointer_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  wire logic idle = !reg_wr_in && !ptr_load_in && !ptr_move_in;  // No request
  wire logic [7:0] c = data_pointer_control_out;
  wire logic [7:0] a = reg_addr_in;
  wire logic [7:0] d = reg_rdata_out;
  wire ddp_pkg::ddp_ptr_t p = active_pointer_out;
  a_rsvd_bits: assert property ((c & 8'h82) == 8'h00)
    else $error("reserved bit set");
  a_ctl_read: assert property ((a == 8'ha7 && idle)[*3] |=> d == c)
    else $error("control read");
  a_low_read: assert property ((a == 8'h82 && idle)[*3] |=> d == p[7:0])
    else $error("low read");
  a_high_read: assert property ((a == 8'h83 && idle)[*3] |=> d == p[15:8])
    else $error("high read");
  a_page_read: assert property ((a == 8'h84 && idle)[*3] |=> d == p[23:16])
    else $error("page read");
  a_ptr_hold: assert property (idle[*2] |=> $stable(p))
    else $error("pointer moved");
  a_swap_off: assert property ((!reg_wr_in)[*2] ##0 !ptr_move_in
    ##1 (!reg_wr_in && ptr_move_in && !c[6]) ##1 !reg_wr_in
    |=> c[0] == $past(c[0], 2)) else $error("select flipped");
  a_swap_on: assert property ((!reg_wr_in)[*2] ##0 !ptr_move_in
    ##1 (!reg_wr_in && ptr_move_in && c[6]) ##1 !reg_wr_in
    |=> c[0] != $past(c[0], 2)) else $error("select kept");
endmodule : ddp_core_sva
bind ddp_core ddp_core_sva ddp_core_sva_inst (.*);

// >>> verif/ddp_core_host.sv
// Core side: register accesses and pointer moves
`timescale 1ns/100ps
module ddp_core_host (
  input  wire logic   clk_in,
  output logic [7:0]  addr_out, wdata_out,
  output logic [2:0]  strobe_out,
  output logic [23:0] data_out
);
  initial {addr_out, wdata_out, strobe_out, data_out} = '0;
  // Hold a request for one edge, then park on the read address
  task automatic req(input logic [7:0] a, d, logic [2:0] s, logic [23:0] v, logic [7:0] r);
    @(posedge clk_in) #1;
    {addr_out, wdata_out, strobe_out, data_out} = {a, d, s, v};
    @(posedge clk_in) #1;
    {addr_out, strobe_out} = {r, 3'h0};
    {wdata_out, data_out} = ~{wdata_out, data_out};  // Released lines wander
  endtask : req
endmodule : ddp_core_host

// >>> verif/dual_data_pointer_ctrl_bench.sv
// Random self-checking bench for the dual data pointer block
`timescale 1ns/100ps
`include "ddp_params.svh"
module dual_data_pointer_ctrl_bench;
  import ddp_pkg::*;
  logic ref_clk_in = 1'b0, reset_n_in = 1'b0, reg_wr_in, ptr_load_in, ptr_move_in;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, data_pointer_control_out, pc, r, w;
  ddp_ptr_t ptr_load_data_in, active_pointer_out, v, x, pt[2];  // Model pointers
  int fails = 0, check_count = 0, cyc = 0, k;
  always #20 ref_clk_in = ~ref_clk_in;
  ddp_core ddp_core_inst (.*);
  ddp_core_host ddp_core_host_inst (.clk_in(ref_clk_in), .addr_out(reg_addr_in),
    .wdata_out(reg_wdata_in), .strobe_out({reg_wr_in, ptr_load_in, ptr_move_in}),
    .data_out(ptr_load_data_in));
  always @(posedge ref_clk_in) if (++cyc > 9000) begin fails++; complete_run(); end
  function automatic ddp_ptr_t adj(ddp_ptr_t p, logic [1:0] m);
    return m == 2'h1 ? p + 24'h1 : m == 2'h2 ? p - 24'h1 : p ^ {23'h0, m[0]};
  endfunction : adj
  task automatic chk(string n, ddp_ptr_t ex, sn);
    check_count++;
    if (sn !== ex)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, ex, sn);
    end
  endtask : chk
  task automatic complete_run();
    if (fails == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  initial
  begin
    void'($urandom(60));
    {pc, pt[0], pt[1]} = '0;
    repeat (10) @(posedge ref_clk_in);
    #1 reset_n_in = 1'b1;
    repeat (600)
    begin
      k = $urandom % 6;
      v = $urandom;
      r = 8'h81 + 8'($urandom % 5);
      if (r == 8'h81) r = 8'ha7;
      w = k == 5 ? pc + 8'h1 : v[7:0];
      ddp_core_host_inst.req(k == 1 ? r : 8'ha7, w, {k < 2 || k == 5, k == 2, k == 3 || k == 4},
                             v, r);
      case (k)
        0, 5: pc = k == 5 ? pc ^ 8'h1 : w & `DDP_CONTROL_MASK;
        1: if (r == 8'ha7) pc = w & `DDP_CONTROL_MASK;
           else if (r < 8'h85) pt[pc[0]][8 * (r - 8'h82) +: 8] = w;
        2: pt[pc[0]] = v;
        default:
        begin
          pt[pc[0]] = adj(pt[pc[0]], pc[0] ? pc[5:4] : pc[3:2]);
          pc[0] ^= pc[6];
        end
      endcase
      repeat (3) @(posedge ref_clk_in);
      #1;
      x = pt[pc[0]] >> (8 * (r - 8'h82));
      chk("ctl", pc, data_pointer_control_out);
      chk("ptr", pt[pc[0]], active_pointer_out);
      chk("rd", r == 8'ha7 ? pc : r < 8'h85 ? x[7:0] : 8'h0, reg_rdata_out);
    end
    complete_run();
  end
endmodule : dual_data_pointer_ctrl_bench
